// >>> design/alt_lin_pkg.sv
package alt_lin_pkg;

  // ----------------------------------------------------------------
  // Register reset values and field codes
  // ----------------------------------------------------------------
  localparam logic [2:0]        HTO_DEFAULT      = 3'h0;
  localparam logic [2:0]        VENDOR_RESET     = 3'h0;
  localparam logic [4:0]        CATEGORY_RESET   = 5'h00;

  localparam logic [2:0]        SEL_ZERO_LOW     = 3'h0;
  localparam logic [2:0]        SEL_SETPOINT     = 3'h1;
  localparam logic [2:0]        SEL_BATTERY      = 3'h2;
  localparam logic [2:0]        SEL_TEMPERATURE  = 3'h3;
  localparam logic [2:0]        SEL_ZERO_HIGH    = 3'h7;

  // High-temperature offset in degrees C for each register code
  localparam logic signed [5:0] HTO_P0  = 6'sh00;
  localparam logic signed [5:0] HTO_M16 = -6'sh10;
  localparam logic signed [5:0] HTO_M12 = -6'sh0C;
  localparam logic signed [5:0] HTO_M8  = -6'sh08;
  localparam logic signed [5:0] HTO_M4  = -6'sh04;
  localparam logic signed [5:0] HTO_P4  = 6'sh04;
  localparam logic signed [5:0] HTO_P8  = 6'sh08;
  localparam logic signed [5:0] HTO_P12 = 6'sh0C;

  // ----------------------------------------------------------------
  // Measurement scaling
  // ----------------------------------------------------------------
  localparam logic [21:0]       CUR_A_FULL_MA    = 22'h1F40;
  localparam logic [21:0]       CUR_A_STEPS      = 22'h3F;
  localparam logic [21:0]       CUR_A_MAX_CODE   = 22'h3F;
  localparam logic [15:0]       CUR_B_LSB_MA     = 16'h0032;
  localparam logic [15:0]       CUR_B_MAX_CODE   = 16'h00FF;

  localparam logic signed [9:0] TEMP_FLOOR_C     = -10'sh026;
  localparam logic [7:0]        TEMP_MAX_CODE    = 8'h3F;

  localparam logic [15:0]       BATT_BASE_MV     = 16'h1F40;
  localparam logic [15:0]       BATT_LSB_MV      = 16'h0064;
  localparam logic [15:0]       BATT_MIN_MV      = 16'h2328;
  localparam logic [15:0]       BATT_MAX_MV      = 16'h3E80;
  localparam logic [7:0]        BATT_MIN_CODE    = 8'h0A;
  localparam logic [7:0]        BATT_MAX_CODE    = 8'h50;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ht_offset;
    logic [2:0] response_indicator;
  } rx_frame_t;

  typedef struct packed {
    logic [7:0]        duty;
    logic [15:0]       current_ma;
    logic signed [8:0] temp_c;
    logic [15:0]       battery_voltage_mv;
    logic [7:0]        setpoint;
  } measure_t;

  typedef struct packed {
    logic overheat;
    logic rotor;
    logic electrical;
  } fault_t;

  typedef struct packed {
    logic       overheat_flag;
    logic       rotor_fault_flag;
    logic       electrical_fault_flag;
    logic       comm_failure_flag;
    logic       comm_timeout_flag;
    logic [4:0] duty_field;
    logic [7:0] current_field;
  } first_response_frame_t;

  typedef struct packed {
    logic       overheat_flag;
    logic       rotor_fault_flag;
    logic       electrical_fault_flag;
    logic       comm_failure_flag;
    logic       comm_timeout_flag;
    logic [2:0] response_selector_field;
    logic [7:0] selectable_field;
  } third_response_frame_t;

endpackage : alt_lin_pkg

// >>> design/alt_lin_regs.sv
// Operation
// - Offset register codes map to 0,-16,-12,-8,-4,+4,+8,+12 degrees C.
// - Duty readback is a 5-bit code in 3.125 percent steps.
// - Duty code goes to its response field; master cannot write it.
// - Current code: 0..63 at 8A/63, or 0..255 at 12.8A/256.
// - Current code goes to the current field of the first response frame.
// - Temperature code 0..63, 0 below -38 C, then 4 C bands.
// - Temperature and voltage appear only in the selectable field.
// - Voltage code: 10 is at most 9V, 8V+0.1V/code, 80 is 16V+.
// - Voltage saturates outside the 9V to 16V measurable window.
// - Read-only 3-bit vendor code sent in its response field.
// - Read-only 5-bit category code sent in its response field.
// - Only vendor and category codes load from non-volatile memory.
// - Failure and timeout flags latch until read out or reset.
// - All other diagnosis flags follow their condition live.
// - Communication failure sets its flag, shown in both frames.
// - Timeout restores the default offset and sets the timeout flag.
// - Overheat flag is live, shown in both frames.
// - Rotor fault flag is live, shown in both frames.
// - Indicator selects setpoint, voltage or temperature; 000/111 zero and default.
// - Electrical fault flag is live, shown in both frames.
`timescale 1ns/1ps
`default_nettype none

module alt_lin_regs (
  input  wire logic                              CLK,
  input  wire logic                              RST,
  input  wire logic                              RX_VALID,
  input  wire alt_lin_pkg::rx_frame_t            RX_FRAME,
  input  wire logic                              FIRST_SENT,
  input  wire logic                              THIRD_SENT,
  input  wire logic                              COMM_FAIL_EVENT,
  input  wire logic                              COMM_TIMEOUT_EVENT,
  input  wire logic                              CUR_VERSION_B,
  input  wire alt_lin_pkg::measure_t             MEASURE,
  input  wire alt_lin_pkg::fault_t               FAULT,
  input  wire logic                              NVM_LOAD,
  input  wire logic [2:0]                        NVM_VENDOR,
  input  wire logic [4:0]                        NVM_CATEGORY,
  output alt_lin_pkg::first_response_frame_t     FIRST_FRAME,
  output alt_lin_pkg::third_response_frame_t     THIRD_FRAME,
  output logic      [2:0]                        VENDOR_FIELD,
  output logic      [4:0]                        CATEGORY_FIELD,
  output logic signed [5:0]                      HT_OFFSET_DEG,
  output logic                                   DEFAULT_RESTORE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0]                          high_temp_threshold_offset;
  logic [2:0]                          indicator;
  logic                                comm_failure_flag;
  logic                                comm_timeout_flag;
  logic [2:0]                          next_offset;
  logic [2:0]                          next_indicator;
  logic                                next_fail;
  logic                                next_timeout;
  logic                                next_restore;
  logic signed [5:0]                   next_ht_deg;
  logic [4:0]                          duty_cycle_readback;
  logic [7:0]                          excitation_current_readback;
  logic [7:0]                          chip_temperature_readback;
  logic [7:0]                          battery_voltage_readback;
  logic [7:0]                          next_select;
  alt_lin_pkg::first_response_frame_t  next_first;
  alt_lin_pkg::third_response_frame_t  next_third;
  logic                                frame_sent;
  logic                                sel_default;

  // Indicator codes 000 and 111 carry no data and force defaults
  function automatic logic is_default_sel(input logic [2:0] sel);
    return (sel == alt_lin_pkg::SEL_ZERO_LOW) || (sel == alt_lin_pkg::SEL_ZERO_HIGH);
  endfunction : is_default_sel

  assign frame_sent  = FIRST_SENT || THIRD_SENT;
  assign sel_default = RX_VALID && is_default_sel(RX_FRAME.response_indicator);

  // ----------------------------------------------------------------
  // Writable offset, indicator and latched flags
  // ----------------------------------------------------------------
  always_comb begin
    next_offset    = high_temp_threshold_offset;
    next_indicator = indicator;
    next_restore   = 1'b0;
    if (RX_VALID) begin
      next_indicator = RX_FRAME.response_indicator;
      if (!sel_default) begin
        next_offset = RX_FRAME.ht_offset;
      end
    end
    // A default request outranks the write carried in the same frame
    if (sel_default || COMM_TIMEOUT_EVENT) begin
      next_offset  = alt_lin_pkg::HTO_DEFAULT;
      next_restore = 1'b1;
    end

    // Clear only after a frame carrying the flag went out; set wins
    next_fail    = (comm_failure_flag && !frame_sent) || COMM_FAIL_EVENT;
    next_timeout = (comm_timeout_flag && !frame_sent) || COMM_TIMEOUT_EVENT;

    unique case (next_offset)
      3'h0: next_ht_deg = alt_lin_pkg::HTO_P0;
      3'h1: next_ht_deg = alt_lin_pkg::HTO_M16;
      3'h2: next_ht_deg = alt_lin_pkg::HTO_M12;
      3'h3: next_ht_deg = alt_lin_pkg::HTO_M8;
      3'h4: next_ht_deg = alt_lin_pkg::HTO_M4;
      3'h5: next_ht_deg = alt_lin_pkg::HTO_P4;
      3'h6: next_ht_deg = alt_lin_pkg::HTO_P8;
      3'h7: next_ht_deg = alt_lin_pkg::HTO_P12;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      high_temp_threshold_offset <= alt_lin_pkg::HTO_DEFAULT;
      indicator                  <= alt_lin_pkg::SEL_ZERO_LOW;
      comm_failure_flag          <= 1'b0;
      comm_timeout_flag          <= 1'b0;
      DEFAULT_RESTORE            <= 1'b0;
      HT_OFFSET_DEG              <= alt_lin_pkg::HTO_P0;
    end else begin
      high_temp_threshold_offset <= next_offset;
      indicator                  <= next_indicator;
      comm_failure_flag          <= next_fail;
      comm_timeout_flag          <= next_timeout;
      DEFAULT_RESTORE            <= next_restore;
      HT_OFFSET_DEG              <= next_ht_deg;
    end
  end

  // ----------------------------------------------------------------
  // Measurement encoders
  // ----------------------------------------------------------------
  always_comb begin
    logic [21:0]       cur_a;
    logic [15:0]       cur_b;
    logic signed [9:0] temp_x;
    logic [9:0]        temp_off;
    logic [7:0]        temp_code;
    logic [15:0]       batt_code;
    cur_a    = 22'h0;
    cur_b    = 16'h0;
    temp_x   = 10'sh000;
    temp_off = 10'h000;
    temp_code = 8'h00;
    batt_code = 16'h0000;

    duty_cycle_readback = MEASURE.duty[7:3];

    // Floor division keeps each code inside its documented band
    if (CUR_VERSION_B) begin
      cur_b = MEASURE.current_ma / alt_lin_pkg::CUR_B_LSB_MA;
      excitation_current_readback = (cur_b > alt_lin_pkg::CUR_B_MAX_CODE)
                                    ? alt_lin_pkg::CUR_B_MAX_CODE[7:0] : cur_b[7:0];
    end else begin
      cur_a = (22'(MEASURE.current_ma) * alt_lin_pkg::CUR_A_STEPS)
              / alt_lin_pkg::CUR_A_FULL_MA;
      excitation_current_readback = (cur_a > alt_lin_pkg::CUR_A_MAX_CODE)
                                    ? alt_lin_pkg::CUR_A_MAX_CODE[7:0] : cur_a[7:0];
    end

    temp_x = 10'(MEASURE.temp_c);
    if (temp_x < alt_lin_pkg::TEMP_FLOOR_C) begin
      chip_temperature_readback = 8'h00;
    end else begin
      temp_off  = 10'(temp_x - alt_lin_pkg::TEMP_FLOOR_C);
      temp_code = 8'(temp_off[9:2]) + 8'h01;
      chip_temperature_readback = (temp_code > alt_lin_pkg::TEMP_MAX_CODE)
                                  ? alt_lin_pkg::TEMP_MAX_CODE : temp_code;
    end

    // Readings outside the measurable window pin to its edges
    if (MEASURE.battery_voltage_mv < alt_lin_pkg::BATT_MIN_MV) begin
      battery_voltage_readback = alt_lin_pkg::BATT_MIN_CODE;
    end else if (MEASURE.battery_voltage_mv >= alt_lin_pkg::BATT_MAX_MV) begin
      battery_voltage_readback = alt_lin_pkg::BATT_MAX_CODE;
    end else begin
      batt_code = (MEASURE.battery_voltage_mv - alt_lin_pkg::BATT_BASE_MV)
                  / alt_lin_pkg::BATT_LSB_MV;
      battery_voltage_readback = batt_code[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Response frames
  // ----------------------------------------------------------------
  always_comb begin
    unique case (indicator)
      alt_lin_pkg::SEL_SETPOINT:    next_select = MEASURE.setpoint;
      alt_lin_pkg::SEL_BATTERY:     next_select = battery_voltage_readback;
      alt_lin_pkg::SEL_TEMPERATURE: next_select = chip_temperature_readback;
      default:                      next_select = 8'h00;
    endcase

    next_first.overheat_flag         = FAULT.overheat;
    next_first.rotor_fault_flag      = FAULT.rotor;
    next_first.electrical_fault_flag = FAULT.electrical;
    next_first.comm_failure_flag     = comm_failure_flag;
    next_first.comm_timeout_flag     = comm_timeout_flag;
    next_first.duty_field            = duty_cycle_readback;
    next_first.current_field         = excitation_current_readback;

    next_third.overheat_flag           = FAULT.overheat;
    next_third.rotor_fault_flag        = FAULT.rotor;
    next_third.electrical_fault_flag   = FAULT.electrical;
    next_third.comm_failure_flag       = comm_failure_flag;
    next_third.comm_timeout_flag       = comm_timeout_flag;
    next_third.response_selector_field = indicator;
    next_third.selectable_field        = next_select;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      FIRST_FRAME <= '0;
      THIRD_FRAME <= '0;
    end else begin
      FIRST_FRAME <= next_first;
      THIRD_FRAME <= next_third;
    end
  end

  // ----------------------------------------------------------------
  // Production codes
  // ----------------------------------------------------------------
  nvm_code_store u_codes (
    .clk                      (CLK),
    .rst                      (RST),
    .load                     (NVM_LOAD),
    .vendor_in                (NVM_VENDOR),
    .category_in              (NVM_CATEGORY),
    .vendor_origin_code       (VENDOR_FIELD),
    .alternator_category_code (CATEGORY_FIELD)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ht_decode_a: assert property (@(posedge CLK) disable iff (RST)
    ((high_temp_threshold_offset != 3'h1) || (HT_OFFSET_DEG == -6'sh10))
      && ((high_temp_threshold_offset != 3'h7) || (HT_OFFSET_DEG == 6'sh0C)))
    else $error("offset decode wrong");

  duty_trunc_a: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> (FIRST_FRAME.duty_field == $past(MEASURE.duty[7:3])))
    else $error("duty field not top five bits");

  cur_sat_a: assert property (@(posedge CLK) disable iff (RST)
    (!CUR_VERSION_B && MEASURE.current_ma >= 16'h1F40) |=>
      (FIRST_FRAME.current_field == 8'h3F))
    else $error("version A current not saturated at 63");

  cur_b_top_a: assert property (@(posedge CLK) disable iff (RST)
    (CUR_VERSION_B && MEASURE.current_ma >= 16'h3138) |=>
      (FIRST_FRAME.current_field >= 8'hFC))
    else $error("version B current code below 252 at 12.6 A");

  temp_low_a: assert property (@(posedge CLK) disable iff (RST)
    (indicator == 3'h3 && MEASURE.temp_c < -9'sh026) |=>
      (THIRD_FRAME.selectable_field == 8'h00))
    else $error("temperature below floor not code 0");

  batt_window_a: assert property (@(posedge CLK) disable iff (RST)
    (indicator == 3'h2) |=> (THIRD_FRAME.selectable_field >= 8'h0A)
                            && (THIRD_FRAME.selectable_field <= 8'h50))
    else $error("voltage code outside window");

  flag_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (comm_failure_flag && !frame_sent) |=> comm_failure_flag [*1] ##1
      (FIRST_FRAME.comm_failure_flag || $past(frame_sent)))
    else $error("failure flag lost before read");

  set_wins_a: assert property (@(posedge CLK) disable iff (RST)
    (COMM_TIMEOUT_EVENT && frame_sent) |=> comm_timeout_flag)
    else $error("timeout flag cleared despite new event");

  flag_clear_a: assert property (@(posedge CLK) disable iff (RST)
    (THIRD_SENT && !COMM_FAIL_EVENT) |=> !comm_failure_flag)
    else $error("failure flag not cleared after frame sent");

  live_flag_a: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> (THIRD_FRAME.overheat_flag == $past(FAULT.overheat))
             && (FIRST_FRAME.electrical_fault_flag == $past(FAULT.electrical)))
    else $error("live flag not following condition");

  timeout_restore_a: assert property (@(posedge CLK) disable iff (RST)
    COMM_TIMEOUT_EVENT |=> DEFAULT_RESTORE && (high_temp_threshold_offset == 3'h0)
      ##1 (THIRD_FRAME.comm_timeout_flag || $past(frame_sent)))
    else $error("timeout did not restore defaults");

  sel_zero_a: assert property (@(posedge CLK) disable iff (RST)
    (RX_VALID && RX_FRAME.response_indicator == 3'h7) |=> (HT_OFFSET_DEG == 6'sh00)
      ##1 (THIRD_FRAME.selectable_field == 8'h00))
    else $error("indicator 111 did not zero field and default offset");

endmodule : alt_lin_regs

`default_nettype wire

// >>> design/nvm_code_store.sv
`timescale 1ns/1ps
`default_nettype none

module nvm_code_store (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [2:0] vendor_in,
  input  wire logic [4:0] category_in,
  output logic      [2:0] vendor_origin_code,
  output logic      [4:0] alternator_category_code
);

  logic [2:0] next_vendor;
  logic [4:0] next_category;

  // ----------------------------------------------------------------
  // Production codes, loaded from non-volatile memory on each load pulse
  // ----------------------------------------------------------------
  always_comb begin
    next_vendor   = vendor_origin_code;
    next_category = alternator_category_code;
    if (load) begin
      next_vendor   = vendor_in;
      next_category = category_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vendor_origin_code       <= alt_lin_pkg::VENDOR_RESET;
      alternator_category_code <= alt_lin_pkg::CATEGORY_RESET;
    end else begin
      vendor_origin_code       <= next_vendor;
      alternator_category_code <= next_category;
    end
  end

  nvm_load_a: assert property (@(posedge clk) disable iff (rst)
    load |=> (vendor_origin_code == $past(vendor_in))
             && (alternator_category_code == $past(category_in)))
    else $error("production codes not taken from memory load");

  nvm_hold_a: assert property (@(posedge clk) disable iff (rst)
    !load |=> $stable(vendor_origin_code) && $stable(alternator_category_code))
    else $error("production code changed without memory load");

endmodule : nvm_code_store

`default_nettype wire

// >>> test/alt_lin_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module alt_lin_regs_tb_top;
  typedef struct {int kind; logic [7:0] exp;} note_t;
  logic                                  CLK = 1'b0;
  logic                                  RST = 1'b1;
  logic                                  RX_VALID, FIRST_SENT, THIRD_SENT, NVM_LOAD = 1'b0;
  logic                                  FAIL_EV = 1'b0, TMO_EV = 1'b0, VER_B = 1'b0;
  logic [2:0]                            NVM_VENDOR = 3'h0;
  logic [4:0]                            NVM_CATEGORY = 5'h00;
  alt_lin_pkg::rx_frame_t                RX_FRAME;
  alt_lin_pkg::measure_t                 MEASURE = '0;
  alt_lin_pkg::fault_t                   FAULT = '0;
  alt_lin_pkg::first_response_frame_t    FIRST_FRAME;
  alt_lin_pkg::third_response_frame_t    THIRD_FRAME;
  logic [2:0]                            VENDOR_FIELD;
  logic [4:0]                            CATEGORY_FIELD;
  logic signed [5:0]                     HT_OFFSET_DEG;
  logic                                  DEFAULT_RESTORE;
  logic signed [5:0]                     ofs [8];
  note_t                                 notes [$];
  event                                  sample_ev;
  int                                    error_cnt = 0;
  int                                    n_checks = 0;
  int                                    restore_cnt = 0;

  always #12.5 CLK = ~CLK;

  lin_master_model i_master (.CLK(CLK), .RX_VALID(RX_VALID), .RX_FRAME(RX_FRAME),
    .FIRST_SENT(FIRST_SENT), .THIRD_SENT(THIRD_SENT));

  alt_lin_regs i_dut (
    .CLK(CLK), .RST(RST), .RX_VALID(RX_VALID), .RX_FRAME(RX_FRAME),
    .FIRST_SENT(FIRST_SENT), .THIRD_SENT(THIRD_SENT),
    .COMM_FAIL_EVENT(FAIL_EV), .COMM_TIMEOUT_EVENT(TMO_EV),
    .CUR_VERSION_B(VER_B), .MEASURE(MEASURE), .FAULT(FAULT),
    .NVM_LOAD(NVM_LOAD), .NVM_VENDOR(NVM_VENDOR), .NVM_CATEGORY(NVM_CATEGORY),
    .FIRST_FRAME(FIRST_FRAME), .THIRD_FRAME(THIRD_FRAME),
    .VENDOR_FIELD(VENDOR_FIELD), .CATEGORY_FIELD(CATEGORY_FIELD),
    .HT_OFFSET_DEG(HT_OFFSET_DEG), .DEFAULT_RESTORE(DEFAULT_RESTORE));

  // Restore pulses stand one cycle, so count them as they pass
  always @(negedge CLK) begin
    if (DEFAULT_RESTORE === 1'b1) restore_cnt++;
  end

  // ----------------------------------------------------------------
  // Scoreboard
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic note(input int kind, input logic [7:0] exp);
    notes.push_back('{kind, exp});
  endtask : note

  // Fixed latency: all registered outputs have landed after three edges
  task automatic settle;
    repeat (3) @(negedge CLK);
    -> sample_ev;
    @(negedge CLK);
  endtask : settle

  always @(sample_ev) begin
    note_t n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.kind)
        0: check({2'b00, HT_OFFSET_DEG}, n.exp);
        1: check({3'b000, FIRST_FRAME.duty_field}, n.exp);
        2: check(FIRST_FRAME.current_field, n.exp);
        3: check(THIRD_FRAME.selectable_field, n.exp);
        4: check({3'b000, FIRST_FRAME[17:13]}, n.exp);
        5: check({3'b000, THIRD_FRAME[15:11]}, n.exp);
        6: check({VENDOR_FIELD, CATEGORY_FIELD}, n.exp);
        7: check({5'h00, THIRD_FRAME.response_selector_field}, n.exp);
        default: check(8'(restore_cnt), n.exp);
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Expected codes
  // ----------------------------------------------------------------
  function automatic logic [7:0] volt_code(input logic [15:0] mv);
    if (mv < alt_lin_pkg::BATT_MIN_MV) return alt_lin_pkg::BATT_MIN_CODE;
    if (mv >= alt_lin_pkg::BATT_MAX_MV) return alt_lin_pkg::BATT_MAX_CODE;
    return 8'((mv - alt_lin_pkg::BATT_BASE_MV) / alt_lin_pkg::BATT_LSB_MV);
  endfunction : volt_code

  function automatic logic [7:0] temp_code(input int t);
    if (t < -38) return 8'h00;
    return ((t + 38) / 4 + 1 > 63) ? 8'h3F : 8'((t + 38) / 4 + 1);
  endfunction : temp_code

  function automatic logic [7:0] cur_code(input int ma, input logic b);
    if (b) return (ma / 50 > 255) ? 8'hFF : 8'(ma / 50);
    return (ma * 63 / 8000 > 63) ? 8'h3F : 8'(ma * 63 / 8000);
  endfunction : cur_code

  task automatic pulse(input logic tmo);
    @(negedge CLK);
    if (tmo) TMO_EV <= 1'b1;
    else FAIL_EV <= 1'b1;
    @(negedge CLK);
    TMO_EV <= 1'b0;
    FAIL_EV <= 1'b0;
  endtask : pulse

  task automatic flags_are(input logic [4:0] f);
    note(4, {3'b000, f});
    note(5, {3'b000, f});
    settle;
  endtask : flags_are

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] sel;
    ofs = '{alt_lin_pkg::HTO_P0, alt_lin_pkg::HTO_M16, alt_lin_pkg::HTO_M12,
            alt_lin_pkg::HTO_M8, alt_lin_pkg::HTO_M4, alt_lin_pkg::HTO_P4,
            alt_lin_pkg::HTO_P8, alt_lin_pkg::HTO_P12};
    sel = 8'($urandom(12));
    repeat (12) @(posedge CLK);
    @(negedge CLK);
    RST = 1'b0;
    note(0, 8'h00);
    note(6, 8'h00);
    flags_are(5'h00);
    for (int i = 0; i < 8; i++) begin
      i_master.send_frame(alt_lin_pkg::SEL_BATTERY, 3'(i));
      note(0, {2'b00, ofs[i]});
      settle;
    end
    $display("test offset decode done");
    for (int r = 0; r < 24; r++) begin
      @(negedge CLK);
      MEASURE = {8'($urandom), 16'($urandom_range(14000)),
                 9'($signed(int'($urandom_range(290)) - 60)),
                 16'($urandom_range(20000)), 8'($urandom)};
      VER_B = 1'($urandom);
      FAULT = 3'($urandom);
      // Force the below-floor temperature and top current corners once
      if (r == 11) begin
        MEASURE.temp_c     = -9'sh032;
        MEASURE.current_ma = 16'h36B0;
        VER_B              = 1'b1;
      end
      i_master.send_frame(3'(r), 3'h5);
      case (3'(r))
        3'h1: sel = MEASURE.setpoint;
        3'h2: sel = volt_code(MEASURE.battery_voltage_mv);
        3'h3: sel = temp_code(int'(MEASURE.temp_c));
        default: sel = 8'h00;
      endcase
      note(3, sel);
      note(7, {5'h00, 3'(r)});
      note(0, (r % 8 == 0 || r % 8 == 7) ? 8'h00 : {2'b00, ofs[5]});
      note(1, {3'b000, MEASURE.duty[7:3]});
      note(2, cur_code(int'(MEASURE.current_ma), VER_B));
      flags_are({FAULT, 2'b00});
    end
    $display("test readbacks and live flags done");
    FAULT = '0;
    pulse(1'b0);
    flags_are(5'h02);
    fork
      i_master.frame_sent(1'b0);
      pulse(1'b0);
    join
    flags_are(5'h02);
    i_master.frame_sent(1'b1);
    flags_are(5'h00);
    i_master.send_frame(alt_lin_pkg::SEL_BATTERY, 3'h6);
    fork
      i_master.frame_sent(1'b1);
      pulse(1'b1);
    join
    note(0, 8'h00);
    note(8, 8'h07);
    flags_are(5'h01);
    i_master.frame_sent(1'b0);
    flags_are(5'h00);
    $display("test latched flags done");
    @(negedge CLK);
    NVM_VENDOR = 3'($urandom);
    NVM_CATEGORY = 5'($urandom);
    NVM_LOAD = 1'b1;
    @(negedge CLK);
    NVM_LOAD = 1'b0;
    note(6, {NVM_VENDOR, NVM_CATEGORY});
    settle;
    pulse(1'b1);
    note(6, {NVM_VENDOR, NVM_CATEGORY});
    note(8, 8'h08);
    settle;
    $display("test production codes done");
    finish_test();
  end
endmodule : alt_lin_regs_tb_top

`default_nettype wire

// >>> test/lin_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module lin_master_model (
  input  wire logic              CLK,
  output logic                   RX_VALID,
  output alt_lin_pkg::rx_frame_t RX_FRAME,
  output logic                   FIRST_SENT,
  output logic                   THIRD_SENT
);
  initial begin
    RX_VALID   = 1'b0;
    RX_FRAME   = '0;
    FIRST_SENT = 1'b0;
    THIRD_SENT = 1'b0;
  end

  // Master writes only offset and indicator; readbacks have no write path
  task automatic send_frame(input logic [2:0] ind, input logic [2:0] off);
    @(negedge CLK);
    RX_FRAME <= {off, ind};
    RX_VALID <= 1'b1;
    @(negedge CLK);
    RX_VALID <= 1'b0;
    // Released data does not hold its last value
    RX_FRAME <= {~off, ~ind};
  endtask : send_frame

  task automatic frame_sent(input logic third);
    @(negedge CLK);
    FIRST_SENT <= ~third;
    THIRD_SENT <= third;
    @(negedge CLK);
    FIRST_SENT <= 1'b0;
    THIRD_SENT <= 1'b0;
  endtask : frame_sent
endmodule : lin_master_model

`default_nettype wire
